/* core/rtc_sec_min_regs.vh */
// Register offsets, field positions, reset values and timing counts for the
// seconds and minutes counter; assumes a 250 MHz aclk.
// Functional notes
// - Seconds held as two BCD digits, software may set 00 to 59.
// - Free-running mode shows seconds register as plain 8-bit read-only counter.
// - Bit 7 of the minutes register, and of seconds outside free-running mode, reads busy while counters update.
// - Seconds tens digit, bits 6 to 4, counts 0 through 5.
// - Seconds units digit counts 0 to 9 each second, carrying on wrap.
// - Units carry increments the tens digit of the same register.
// - Minutes advance by one on each seconds carry.
// - Minutes tens digit, bits 6 to 4, counts 0 through 5.
// - Minutes units digit counts 0 to 9 per minute, carrying into tens.
// - Minutes emit an hourly carry when wrapping past 59.
`ifndef RTC_SEC_MIN_REGS_VH
`define RTC_SEC_MIN_REGS_VH
`define SECONDS_COUNT_ADDR  4'h0
`define MINUTES_COUNT_ADDR  4'h4
`define CONTROL_ADDR        4'h8
`define BUSY_BIT            7
`define TENS_MSB            6
`define TENS_LSB            4
`define UNITS_MSB           3
`define CTRL_RUN_BIT        0
`define CTRL_FREE_BIT       1
`define CONTROL_RESET       2'b01
`define COUNT_RESET         8'h00
`define TICK_PERIOD_NS      1000000000
`define CLK_PERIOD_NS       4
`define TICK_CYCLES         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define BUSY_CYCLES         2'd2
`define AXI_OKAY            2'b00
`define AXI_SLVERR          2'b10
`endif

/* core/bcd_digit_pair.v */
// Two-digit BCD counter with tens limit and load port.
// Assumes step and load never come from another clock domain.
`timescale 1ns/1ns
`default_nettype none
module bcd_digit_pair (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       step,
  input  wire       load,
  input  wire [6:0] load_value,
  output reg  [6:0] value,
  output wire       wrap
);
  assign wrap = step && (value == 7'h59);
  always @(posedge aclk) begin
    if (!aresetn) begin
      value <= 7'h00;
    end else if (load) begin
      value <= load_value;
    end else if (step) begin
      if (value[3:0] == 4'h9) begin
        value[3:0] <= 4'h0;
        if (value[6:4] == 3'h5) begin
          value[6:4] <= 3'h0;
        end else begin
          value[6:4] <= value[6:4] + 3'h1;
        end
      end else begin
        value[3:0] <= value[3:0] + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* core/tick_divider.v */
// Divides aclk down to a one-cycle tick once per period.
// Assumes aclk is the time base and runs free.
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter [31:0] period = 32'd250000000
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire enable,
  output reg  tick
);
  reg [31:0] count;
  always @(posedge aclk) begin
    if (!aresetn || !enable) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == period - 32'h1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/rtc_sec_min.v */
// Seconds and minutes counters of the real-time clock behind AXI4-Lite.
// Assumes a single 250 MHz aclk; the hour counter takes minute_carry.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_sec_min_regs.vh"
module rtc_sec_min #(
  parameter [31:0] tick_cycles = `TICK_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         minute_carry
);
  reg  [1:0]  control;
  reg  [7:0]  free_count;
  reg  [1:0]  busy_count;
  reg         busy;
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        tick;
  wire        sec_wrap;
  wire        min_wrap;
  wire [6:0]  sec_value;
  wire [6:0]  min_value;
  wire        run;
  wire        free_mode;
  wire        do_write;
  wire        load_sec;
  wire        load_min;

  assign run       = control[`CTRL_RUN_BIT];
  assign free_mode = control[`CTRL_FREE_BIT];
  assign do_write  = aw_held && w_held && !s_axi_bvalid;
  assign load_sec  = do_write && aw_addr == `SECONDS_COUNT_ADDR && w_strb[0];
  assign load_min  = do_write && aw_addr == `MINUTES_COUNT_ADDR && w_strb[0];

  function [7:0] time_byte;
    input       busy_flag;
    input [6:0] digits;
    begin
      time_byte = {busy_flag, digits};
    end
  endfunction

  tick_divider #(
    .period (tick_cycles)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (run),
    .tick    (tick)
  );

  bcd_digit_pair u_sec (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .step       (tick && !free_mode),
    .load       (load_sec),
    .load_value (w_data[`TENS_MSB:0]),
    .value      (sec_value),
    .wrap       (sec_wrap)
  );

  bcd_digit_pair u_min (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .step       (sec_wrap),
    .load       (load_min),
    .load_value (w_data[`TENS_MSB:0]),
    .value      (min_value),
    .wrap       (min_wrap)
  );

  // Carry out to the hour counter and free-running counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      minute_carry <= 1'b0;
      free_count   <= `COUNT_RESET;
    end else begin
      minute_carry <= min_wrap;
      if (tick && free_mode) begin
        free_count <= free_count + 8'h01;
      end
    end
  end

  // Busy stands from the tick until the counters have settled
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_count <= 2'h0;
      busy       <= 1'b0;
    end else if (tick) begin
      busy_count <= `BUSY_CYCLES;
      busy       <= 1'b1;
    end else if (busy_count != 2'h0) begin
      busy_count <= busy_count - 2'h1;
      busy       <= (busy_count != 2'h1);
    end else begin
      busy       <= 1'b0;
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      control       <= `CONTROL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `SECONDS_COUNT_ADDR ||
            aw_addr == `MINUTES_COUNT_ADDR) begin
          s_axi_bresp <= `AXI_OKAY;
        end else if (aw_addr == `CONTROL_ADDR) begin
          s_axi_bresp <= `AXI_OKAY;
          if (w_strb[0]) begin
            control <= w_data[1:0];
          end
        end else begin
          s_axi_bresp <= `AXI_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `AXI_OKAY;
      if (s_axi_araddr == `SECONDS_COUNT_ADDR) begin
        if (free_mode) begin
          s_axi_rdata <= {24'h0, free_count};
        end else begin
          s_axi_rdata <= {24'h0, time_byte(busy, sec_value)};
        end
      end else if (s_axi_araddr == `MINUTES_COUNT_ADDR) begin
        s_axi_rdata <= {24'h0, time_byte(busy, min_value)};
      end else if (s_axi_araddr == `CONTROL_ADDR) begin
        s_axi_rdata <= {30'h0, control};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `AXI_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/rtc_sec_min_checker.sv */
// Handshake and field checks for the seconds and minutes block.
// Assumes a bind onto rtc_sec_min; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module rtc_sec_min_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        minute_carry
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_ans; s_axi_rvalid && !s_axi_arready; endsequence
  property p_rd; s_rd_take |=> s_rd_ans; endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_units; s_axi_rvalid |-> s_axi_rdata[3:0] <= 4'h9; endproperty
  property p_tens; s_axi_rvalid |-> s_axi_rdata[6:4] <= 3'h5; endproperty
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_carry; minute_carry |=> !minute_carry [*8]; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_wbusy: assert property (p_wbusy) else $error("ready during response");
  a_units: assert property (p_units) else $error("units digit above 9");
  a_tens: assert property (p_tens) else $error("tens digit above 5");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_carry: assert property (p_carry) else $error("carry too long");
endmodule
bind rtc_sec_min rtc_sec_min_checker u_chk (.*);
`default_nettype wire

/* tb/tb_rtc_sec_min.sv */
// Self-checking bench for the seconds and minutes block.
// Assumes the register map header; drives AXI4-Lite directly.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_sec_min_regs.vh"
module tb_rtc_sec_min;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, minute_carry;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, got, lfsr;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  sec, mn;
  int          err_count = 0, tests_run = 0, carries = 0;
  rtc_sec_min #(.tick_cycles(32'd40)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .minute_carry(minute_carry));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (minute_carry) carries++;
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h5a5a5a, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    got  = rdata;
    resp = rresp;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] inc(input logic [7:0] v);
    if (v[3:0] != 4'h9) return v + 8'h01;
    if (v[6:4] != 3'h5) return {1'b0, v[6:4] + 3'h1, 4'h0};
    return 8'h00;
  endfunction
  // Run until the seconds move once, stop, then compare with the model
  task automatic step(input logic [7:0] s, m);
    wr(`SECONDS_COUNT_ADDR, s);
    wr(`MINUTES_COUNT_ADDR, m);
    wr(`CONTROL_ADDR, 8'h01);
    got = {24'h0, s};
    while (got[6:0] == s[6:0]) rd(`SECONDS_COUNT_ADDR);
    wr(`CONTROL_ADDR, 8'h00);
    do rd(`SECONDS_COUNT_ADDR); while (got[7]);
    chk("sec", got, {24'h0, inc(s)});
    rd(`MINUTES_COUNT_ADDR);
    chk("min", got, {24'h0, s == 8'h59 ? inc(m) : m});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'hf;
    lfsr  = 32'hf787;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SECONDS_COUNT_ADDR);
    chk("sec0", got, 32'h0);
    rd(`CONTROL_ADDR);
    chk("ctl0", got, 32'h1);
    wr(`CONTROL_ADDR, 8'h00);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      sec  = {1'b1, 3'(lfsr[7:0] % 8'd6), 4'(lfsr[15:8] % 8'd10)};
      mn   = {1'b1, 3'(lfsr[23:16] % 8'd6), 4'(lfsr[31:24] % 8'd10)};
      wr(`SECONDS_COUNT_ADDR, sec);
      wr(`MINUTES_COUNT_ADDR, mn);
      rd(`SECONDS_COUNT_ADDR);
      chk("wsec", got, {25'h0, sec[6:0]});
      rd(`MINUTES_COUNT_ADDR);
      chk("wmin", got, {25'h0, mn[6:0]});
    end
    wr(4'hc, 8'h11);
    chk("bresp", {30'h0, resp}, {30'h0, `AXI_SLVERR});
    rd(4'hc);
    chk("rresp", {30'h0, resp}, {30'h0, `AXI_SLVERR});
    wr(`CONTROL_ADDR, 8'h03);
    repeat (45) @(posedge aclk);
    wr(`CONTROL_ADDR, 8'h02);
    rd(`SECONDS_COUNT_ADDR);
    chk("free", got, 32'h1);
    step(8'h09, 8'h00);
    step(8'h59, 8'h09);
    step(8'h59, 8'h59);
    step({1'b0, sec[6:0]}, {1'b0, mn[6:0]});
    chk("carry", 32'(carries), (sec[6:0] == 7'h59 && mn[6:0] == 7'h59) ? 32'h2 : 32'h1);
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    complete_run;
  end
endmodule
`default_nettype wire
